// [hw/pbsp_burst_sram_port.sv]
// Operation
// R1: During a burst only address bits 1:0 step, linear or interleaved per order select.
// R2: A burst running past four words wraps back to its starting word.
// R3: A load edge (advance-or-load low) ends the burst and loads new address and control.
// R4: While advancing, the read-write select input is ignored.
// R5: Burst direction is fixed by read-write select sampled on the load edge.
// R6: Controller drives valid byte-lane write enables on every write cycle, advancing too.
// R7: Read-write select low on a selected load edge starts a write.
// R8: Byte-lane write enables are sampled two edges before their write data.
// R9: A gated edge is absent: burst state and pipeline hold their values.
// R10: Controller drives the high select as inverse of the two low selects.
// R11: Read data appears, write data is taken, two enabled edges after address.
// R12: Data bus floats two enabled edges after a deselect or a write start.
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
module pbsp_burst_sram_port (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic CLOCK_EDGE_GATE_N,
  input wire logic ADVANCE_OR_LOAD,
  input wire logic READ_NOT_WRITE,
  input wire logic [pbsp_pkg::ADDR_W-1:0] ADDR,
  input wire logic CHIP_SELECT_LOW_A,
  input wire logic CHIP_SELECT_LOW_B,
  input wire logic CHIP_SELECT_HIGH,
  input wire logic [pbsp_pkg::LANES-1:0] BYTE_LANE_WRITE_N,
  input wire logic BURST_ORDER_SELECT,
  input wire logic [pbsp_pkg::DATA_W-1:0] DQ_I,
  output logic [pbsp_pkg::DATA_W-1:0] DQ_O,
  output logic DQ_OE_N,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [pbsp_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [pbsp_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP
);
  import pbsp_pkg::*;

  typedef struct packed {
    pbsp_burst_t fsm;
    logic [ADDR_W-1:0] base;
    logic [1:0] count;
    pbsp_stage_t s1;
    pbsp_stage_t s2;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe_n;
    logic port_en;
    logic trace_en;
    logic trace_ovf;
    logic aw_held;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pbsp_main_t;

  pbsp_main_t st;
  pbsp_main_t next_st;
  logic edge_en;
  logic sel;
  logic [1:0] step;
  logic [1:0] low_bits;
  logic [DATA_W-1:0] rd_word;
  logic trace_push;
  logic trace_ready;
  logic trace_pop;
  logic trace_avail;
  pbsp_trace_t trace_in;
  pbsp_trace_t trace_head;
  logic [TRACE_LVL_W-1:0] trace_level;
  logic [AXI_ADDR_W-1:0] rd_addr;
  logic [AXI_ADDR_W-1:0] wr_addr;

  assign edge_en = !CLOCK_EDGE_GATE_N;
  // All three selects must agree; a cleared port enable looks like a deselect.
  assign sel = !CHIP_SELECT_LOW_A && !CHIP_SELECT_LOW_B && CHIP_SELECT_HIGH && st.port_en;
  assign step = st.count + 2'h1;
  assign low_bits = BURST_ORDER_SELECT ? (st.base[1:0] ^ step)
                                       : (st.base[1:0] + step); // see R1
  assign rd_addr = {S_AXI_ARADDR[AXI_ADDR_W-1:2], 2'h0};
  assign wr_addr = {st.awaddr[AXI_ADDR_W-1:2], 2'h0};

  // Each byte lane keeps its own array so that the lane enables gate the writes.
  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [0:(1 << ADDR_W)-1];
      assign rd_word[l*LANE_W +: LANE_W] = lane_mem[st.s2.addr];
      always_ff @(posedge SYS_CLK) begin
        if (edge_en && st.s2.valid && st.s2.write && !st.s2.bw_n[l]) begin // see R8
          lane_mem[st.s2.addr] <= DQ_I[l*LANE_W +: LANE_W]; // see R11
        end
      end
    end
  endgenerate

  assign trace_push = edge_en && st.s2.valid && st.trace_en;
  assign trace_in.write = st.s2.write;
  assign trace_in.addr = st.s2.addr;
  assign trace_in.data = st.s2.write ? DQ_I : rd_word;
  assign trace_pop = st.arready && S_AXI_ARVALID && (rd_addr == REG_TRACE_DATA);

  // The trace buffer lets software watch finished transfers; when it is full
  // new entries are dropped and flagged rather than stalling the memory port.
  pbsp_fifo #(
    .WIDTH(TRACE_W),
    .DEPTH(TRACE_DEPTH)
  ) u_trace (
    .clk(SYS_CLK),
    .nrst(NRST),
    .in_valid(trace_push),
    .in_ready(trace_ready),
    .in_data(trace_in),
    .out_valid(trace_avail),
    .out_ready(trace_pop),
    .out_data(trace_head),
    .level(trace_level)
  );

  always_comb begin
    next_st = st;
    if (edge_en) begin // see R9
      next_st.s2 = st.s1;
      if (!ADVANCE_OR_LOAD) begin // see R3
        next_st.count = 2'h0;
        next_st.base = ADDR;
        next_st.s1.valid = sel;
        next_st.s1.write = !READ_NOT_WRITE; // see R7
        next_st.s1.addr = ADDR;
        next_st.s1.bw_n = BYTE_LANE_WRITE_N;
        if (!sel) begin
          next_st.fsm = BURST_IDLE;
        end else if (READ_NOT_WRITE) begin
          next_st.fsm = BURST_READ; // see R5
        end else begin
          next_st.fsm = BURST_WRITE; // see R5
        end
      end else if (st.fsm != BURST_IDLE) begin
        // Direction comes from the burst, never from the select pin now.
        next_st.count = step; // see R2
        next_st.s1.valid = 1'h1;
        next_st.s1.write = (st.fsm == BURST_WRITE); // see R4
        next_st.s1.addr = {st.base[ADDR_W-1:2], low_bits}; // see R1
        next_st.s1.bw_n = BYTE_LANE_WRITE_N; // see R6
      end else begin
        next_st.s1.valid = 1'h0;
      end
      next_st.dq_oe_n = !(st.s2.valid && !st.s2.write); // see R12
      if (st.s2.valid && !st.s2.write) begin
        next_st.dq_o = rd_word; // see R11
      end
    end

    if (st.awready && S_AXI_AWVALID) begin
      next_st.aw_held = 1'h1;
      next_st.awaddr = S_AXI_AWADDR;
    end
    if (st.wready && S_AXI_WVALID) begin
      next_st.w_held = 1'h1;
      next_st.wdata = S_AXI_WDATA;
      next_st.wstrb = S_AXI_WSTRB;
    end
    if (st.bvalid && S_AXI_BREADY) begin
      next_st.bvalid = 1'h0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'h0;
      next_st.w_held = 1'h0;
      next_st.bvalid = 1'h1;
      next_st.bresp = RESP_OKAY;
      case (wr_addr)
        REG_CTRL: begin
          if (st.wstrb[0]) begin
            next_st.port_en = st.wdata[CTRL_PORT_EN_BIT];
            next_st.trace_en = st.wdata[CTRL_TRACE_EN_BIT];
          end
        end
        REG_STATUS: begin
          if (st.wstrb[0] && st.wdata[STAT_OVF_BIT]) begin
            next_st.trace_ovf = 1'h0;
          end
        end
        REG_TRACE_INFO, REG_TRACE_DATA: begin
          next_st.bresp = RESP_OKAY;
        end
        default: begin
          next_st.bresp = RESP_SLVERR;
        end
      endcase
    end
    // A drop in the same cycle as the clear keeps the flag set.
    if (trace_push && !trace_ready) begin
      next_st.trace_ovf = 1'h1;
    end

    if (st.rvalid && S_AXI_RREADY) begin
      next_st.rvalid = 1'h0;
    end
    if (st.arready && S_AXI_ARVALID) begin
      next_st.rvalid = 1'h1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = 32'h0;
      case (rd_addr)
        REG_CTRL: begin
          next_st.rdata[CTRL_PORT_EN_BIT] = st.port_en;
          next_st.rdata[CTRL_TRACE_EN_BIT] = st.trace_en;
        end
        REG_STATUS: begin
          next_st.rdata[STAT_FSM_LSB +: 3] = st.fsm;
          next_st.rdata[STAT_COUNT_LSB +: 2] = st.count;
          next_st.rdata[STAT_OVF_BIT] = st.trace_ovf;
          next_st.rdata[STAT_AVAIL_BIT] = trace_avail;
          next_st.rdata[STAT_LEVEL_LSB +: TRACE_LVL_W] = trace_level;
        end
        REG_TRACE_INFO: begin
          next_st.rdata[ADDR_W-1:0] = trace_head.addr;
          next_st.rdata[INFO_DATA_HI_LSB +: 4] = trace_head.data[DATA_W-1:32];
          next_st.rdata[INFO_WRITE_BIT] = trace_head.write;
          next_st.rdata[INFO_VALID_BIT] = trace_avail;
        end
        REG_TRACE_DATA: begin
          next_st.rdata = trace_head.data[31:0];
        end
        default: begin
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      st <= '0;
      st.fsm <= BURST_IDLE;
      st.dq_oe_n <= 1'h1;
      st.port_en <= CTRL_PORT_EN_RST;
      st.trace_en <= CTRL_TRACE_EN_RST;
    end else begin
      st <= next_st;
    end
  end

  assign DQ_O = st.dq_o;
  assign DQ_OE_N = st.dq_oe_n;
  assign S_AXI_AWREADY = st.awready;
  assign S_AXI_WREADY = st.wready;
  assign S_AXI_BVALID = st.bvalid;
  assign S_AXI_BRESP = st.bresp;
  assign S_AXI_ARREADY = st.arready;
  assign S_AXI_RVALID = st.rvalid;
  assign S_AXI_RDATA = st.rdata;
  assign S_AXI_RRESP = st.rresp;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);

  sequence load_read_s;
    edge_en && !ADVANCE_OR_LOAD && sel && READ_NOT_WRITE;
  endsequence

  sequence load_write_s;
    edge_en && !ADVANCE_OR_LOAD && sel && !READ_NOT_WRITE;
  endsequence

  read_latency_a: assert property ( // see R11
    load_read_s ##1 edge_en ##1 edge_en |=> !DQ_OE_N)
    else $error("Read data not driven two enabled edges after address.");

  write_float_a: assert property ( // see R12
    load_write_s ##1 edge_en ##1 edge_en |=> DQ_OE_N)
    else $error("Bus still driven two enabled edges after a write start.");

  gated_hold_a: assert property ( // see R9
    !edge_en |=> $stable(st.fsm) && $stable(st.count) && $stable(st.s1) && $stable(st.s2)
                 && $stable(DQ_OE_N) && $stable(DQ_O))
    else $error("Burst or pipeline changed on a gated edge.");

  burst_wrap_a: assert property ( // see R2
    edge_en && ADVANCE_OR_LOAD && st.fsm != BURST_IDLE && st.count == 2'h3
    |=> st.count == 2'h0 && st.s1.addr == st.base)
    else $error("Burst did not wrap to its starting word.");

  low_bits_a: assert property ( // see R1
    edge_en && ADVANCE_OR_LOAD && st.fsm != BURST_IDLE
    |=> st.s1.addr[ADDR_W-1:2] == $past(st.base[ADDR_W-1:2]) && st.s1.addr != $past(st.s1.addr))
    else $error("Advance touched upper address bits or did not step.");

  burst_dir_a: assert property ( // see R4
    edge_en && ADVANCE_OR_LOAD && st.fsm != BURST_IDLE
    |=> $stable(st.fsm) && st.s1.write == (st.fsm == BURST_WRITE))
    else $error("Burst direction changed while advancing.");

  write_start_a: assert property ( // see R7
    load_write_s |=> st.fsm == BURST_WRITE && st.s1.valid && st.s1.write)
    else $error("Selected load with write select low did not start a write.");

  load_end_a: assert property ( // see R3
    edge_en && !ADVANCE_OR_LOAD && !sel |=> st.fsm == BURST_IDLE && !st.s1.valid)
    else $error("Deselected load did not end the burst.");

  lane_sample_a: assert property ( // see R8
    load_write_s ##1 edge_en |=> st.s2.bw_n == $past(BYTE_LANE_WRITE_N, 2))
    else $error("Byte lane enables not carried with the write address.");

  resp_hold_a: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("Write response dropped before it was taken.");

  read_wrap_c: cover property (
    load_read_s ##1 (edge_en && ADVANCE_OR_LOAD)[*4]);
  write_burst_c: cover property (
    load_write_s ##1 (edge_en && ADVANCE_OR_LOAD) ##1 edge_en ##1 edge_en);
  gated_read_c: cover property (load_read_s ##1 !edge_en ##1 edge_en ##1 edge_en);
  trace_drop_c: cover property (trace_push && !trace_ready);

endmodule

// [hw/pbsp_pkg.sv]
package pbsp_pkg;

  localparam int ADDR_W = 17;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int TRACE_DEPTH = 8;
  localparam int TRACE_LVL_W = 4;
  localparam int AXI_ADDR_W = 5;

  // Register byte addresses on the AXI4-Lite slave.
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 5'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_TRACE_INFO = 5'h08;
  localparam logic [AXI_ADDR_W-1:0] REG_TRACE_DATA = 5'h0C;

  // Control register fields and their values after reset.
  localparam int CTRL_PORT_EN_BIT = 0;
  localparam int CTRL_TRACE_EN_BIT = 1;
  localparam logic CTRL_PORT_EN_RST = 1'h1;
  localparam logic CTRL_TRACE_EN_RST = 1'h0;

  // Status register fields.
  localparam int STAT_FSM_LSB = 0;
  localparam int STAT_COUNT_LSB = 3;
  localparam int STAT_OVF_BIT = 5;
  localparam int STAT_AVAIL_BIT = 6;
  localparam int STAT_LEVEL_LSB = 7;

  // Trace information register fields.
  localparam int INFO_DATA_HI_LSB = 24;
  localparam int INFO_WRITE_BIT = 28;
  localparam int INFO_VALID_BIT = 31;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    BURST_IDLE = 3'h1,
    BURST_READ = 3'h2,
    BURST_WRITE = 3'h4
  } pbsp_burst_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] bw_n;
  } pbsp_stage_t;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pbsp_trace_t;

  localparam int TRACE_W = $bits(pbsp_trace_t);

endpackage

// [hw/pbsp_fifo.sv]
module pbsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW:0] wr_ptr;
    logic [PW:0] rd_ptr;
  } pbsp_fifo_state_t;

  pbsp_fifo_state_t st;
  pbsp_fifo_state_t next_st;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic full;
  logic empty;

  // The extra pointer bit tells a full buffer from an empty one.
  assign full = (st.wr_ptr[PW] != st.rd_ptr[PW]) &&
                (st.wr_ptr[PW-1:0] == st.rd_ptr[PW-1:0]);
  assign empty = (st.wr_ptr == st.rd_ptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[st.rd_ptr[PW-1:0]];
  assign level = st.wr_ptr - st.rd_ptr;

  always_comb begin
    next_st = st;
    if (in_valid && !full) begin
      next_st.wr_ptr = st.wr_ptr + 1'h1;
    end
    if (out_ready && !empty) begin
      next_st.rd_ptr = st.rd_ptr + 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[st.wr_ptr[PW-1:0]] <= in_data;
    end
  end

  fifo_no_overrun_a: assert property (@(posedge clk) disable iff (!nrst)
    full |=> (st.wr_ptr == $past(st.wr_ptr)) || $past(out_ready))
    else $error("Trace buffer accepted a word while full.");

endmodule

// [test/pbsp_ctrl_model.sv]
module pbsp_ctrl_model (
  input wire logic clk,
  output logic gate_n,
  output logic advance_or_load,
  output logic rnw,
  output logic [pbsp_pkg::ADDR_W-1:0] addr,
  output logic cs_low_a,
  output logic cs_low_b,
  output logic cs_high,
  output logic [pbsp_pkg::LANES-1:0] lane_n,
  output logic order,
  output logic [pbsp_pkg::DATA_W-1:0] dq_i,
  input wire logic [pbsp_pkg::DATA_W-1:0] dq_o,
  input wire logic dq_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import pbsp_pkg::*;
  logic [2:0] pv = '0;
  logic [2:0] pw = '0;
  logic [DATA_W-1:0] pd [2];
  logic [DATA_W-1:0] op_d = '0;
  logic [DATA_W-1:0] last_d = '0;
  logic bact = 1'b0;
  logic bwr = 1'b0;
  logic [DATA_W:0] rq [$];

  initial begin
    gate_n = 1'b0;
    advance_or_load = 1'b0;
    rnw = 1'b1;
    addr = '0;
    cs_low_a = 1'b1;
    cs_low_b = 1'b1;
    cs_high = 1'b0;
    lane_n = '1;
    order = 1'b0;
  end

  // Off-transfer the bus shows the inverse of its last word, so stale data never matches.
  assign dq_i = pw[1] ? pd[1] : ~last_d;

  always @(posedge clk) begin
    if (!gate_n) begin
      if (pv[2] && !pw[2]) begin
        rq.push_back({dq_oe_n, dq_o});
      end
      if (pw[1]) begin
        last_d <= pd[1];
      end
      if (!advance_or_load) begin
        bact <= !cs_low_a;
        bwr <= !rnw;
      end
      pv <= {pv[1:0], advance_or_load ? bact : !cs_low_a};
      pw <= {pw[1:0], advance_or_load ? bact && bwr : !cs_low_a && !rnw};
      pd[1] <= pd[0];
      pd[0] <= op_d;
    end
  end

  task automatic cyc(input logic g, input logic ld, input logic rw, input logic sel,
                     input logic ord, input logic [ADDR_W-1:0] a,
                     input logic [LANES-1:0] bw, input logic [DATA_W-1:0] d);
    @(posedge clk);
    gate_n <= g;
    advance_or_load <= ld;
    rnw <= rw;
    addr <= a;
    cs_low_a <= !sel;
    cs_low_b <= !sel;
    cs_high <= sel;
    lane_n <= bw;
    order <= ord;
    op_d <= d;
  endtask
endmodule

// [test/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pbsp_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  logic [AXI_ADDR_W-1:0] awa = '0;
  logic [AXI_ADDR_W-1:0] ara = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rd;
  logic awr, wrr, bv, arr, rv, g_n, ld, rw, csa, csb, csh, ord, oe_n;
  logic [1:0] br, rr;
  logic [ADDR_W-1:0] ad;
  logic [LANES-1:0] bw_n;
  logic [DATA_W-1:0] dqi, dqo;
  logic [DATA_W-1:0] mem_e [int];
  logic [DATA_W:0] eq [$];
  int seq = 0;
  int n_mismatch = 0;
  int n_compared = 0;

  initial begin
    forever #2 clk = ~clk;
  end

  pbsp_burst_sram_port DUT (.SYS_CLK(clk), .NRST(nrst), .CLOCK_EDGE_GATE_N(g_n),
    .ADVANCE_OR_LOAD(ld), .READ_NOT_WRITE(rw), .ADDR(ad), .CHIP_SELECT_LOW_A(csa),
    .CHIP_SELECT_LOW_B(csb), .CHIP_SELECT_HIGH(csh), .BYTE_LANE_WRITE_N(bw_n),
    .BURST_ORDER_SELECT(ord), .DQ_I(dqi), .DQ_O(dqo), .DQ_OE_N(oe_n),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrr), .S_AXI_WDATA(wdat), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rd),
    .S_AXI_RRESP(rr));

  pbsp_ctrl_model pm (.clk(clk), .gate_n(g_n), .advance_or_load(ld), .rnw(rw), .addr(ad),
    .cs_low_a(csa), .cs_low_b(csb), .cs_high(csh), .lane_n(bw_n), .order(ord),
    .dq_i(dqi), .dq_o(dqo), .dq_oe_n(oe_n));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wdat <= d;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
    end while (bv !== 1'b1);
    // Response ready comes late on purpose, so the slave has to hold its response.
    bry <= 1'b1;
    @(posedge clk);
    r = br;
    bry <= 1'b0;
  endtask

  task automatic axi_rd(input logic [AXI_ADDR_W-1:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rd;
    r = rr;
    rry <= 1'b0;
  endtask

  task automatic drain();
    repeat (5) pm.cyc(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, '0, '1, '0);
    check(pm.rq.size(), eq.size());
    while (eq.size() > 0) check(pm.rq.pop_front(), eq.pop_front());
    pm.rq.delete();
  endtask

  // Advancing words carry a wrong direction and address; gated edges carry a bogus load.
  task automatic burst(input logic wr, input logic il, input logic [ADDR_W-1:0] base,
                       input int n, input logic [LANES-1:0] bw, input logic gate);
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    for (int k = 0; k < n; k++) begin
      a = base;
      a[1:0] = il ? base[1:0] ^ 2'(k) : base[1:0] + 2'(k);
      d = {bw, 32'(seq * 32'h01030507)};
      seq++;
      if (gate) pm.cyc(1'b1, 1'b0, wr, 1'b1, !il, ~a, ~bw, ~d);
      pm.cyc(1'b0, k > 0, (k > 0) ? wr : !wr, 1'b1, il, (k > 0) ? ~a : base, bw, d);
      if (wr) begin
        for (int l = 0; l < LANES; l++) begin
          if (!bw[l]) mem_e[a][l*LANE_W +: LANE_W] = d[l*LANE_W +: LANE_W];
        end
      end else begin
        eq.push_back({1'b0, mem_e[a]});
      end
    end
    drain();
  endtask

  task automatic s_regs();
    logic [31:0] v;
    logic [1:0] r;
    axi_rd(REG_CTRL, v, r);
    check(v, 32'h1);
    axi_rd(REG_STATUS, v, r);
    check(v, 32'h1);
    axi_rd(5'h10, v, r);
    check(r, RESP_SLVERR);
    axi_wr(5'h14, 32'h0, r);
    check(r, RESP_SLVERR);
  endtask

  task automatic s_float();
    logic [1:0] r;
    pm.cyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 17'h00102, '1, '0);
    pm.cyc(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 17'h00040, 4'h0, 36'h5A5A5A5A5);
    pm.cyc(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, '0, '1, '0);
    pm.cyc(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, '0, '1, '0);
    #1 check(oe_n, 1'b0);
    pm.cyc(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, '0, '1, '0);
    #1 check(oe_n, 1'b1);
    mem_e[17'h00040] = 36'h5A5A5A5A5;
    eq.push_back({1'b0, mem_e[17'h00102]});
    drain();
    burst(1'b0, 1'b0, 17'h00040, 1, '1, 1'b0);
    // With the port disabled a selected read load must behave as a deselect.
    axi_wr(REG_CTRL, 32'h0, r);
    check(r, RESP_OKAY);
    pm.cyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 17'h00040, '1, '0);
    repeat (3) pm.cyc(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, '0, '1, '0);
    #1 check(oe_n, 1'b1);
    axi_wr(REG_CTRL, 32'h1, r);
    pm.rq.delete();
  endtask

  task automatic s_trace();
    logic [31:0] v;
    logic [1:0] r;
    axi_wr(REG_CTRL, 32'h3, r);
    burst(1'b0, 1'b0, 17'h000A4, 9, '1, 1'b0);
    axi_rd(REG_STATUS, v, r);
    check(v & 32'h7E7, 32'h461);
    axi_rd(REG_TRACE_INFO, v, r);
    check({v[31], v[28], v[27:24], v[16:0]}, {2'b10, mem_e[17'h000A4][35:32], 17'h000A4});
    for (int k = 0; k < 8; k++) begin
      axi_rd(REG_TRACE_DATA, v, r);
      check(v, mem_e[17'h000A4 + k % 4][31:0]);
    end
    axi_wr(REG_STATUS, 32'h20, r);
    axi_rd(REG_STATUS, v, r);
    check(v & 32'h7E7, 32'h1);
    axi_wr(REG_CTRL, 32'h1, r);
  endtask

  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    s_regs();
    burst(1'b1, 1'b0, 17'h00102, 5, 4'h0, 1'b0);
    burst(1'b0, 1'b0, 17'h00102, 6, '1, 1'b0);
    burst(1'b1, 1'b1, 17'h000A5, 4, 4'h0, 1'b1);
    burst(1'b0, 1'b1, 17'h000A5, 5, '1, 1'b1);
    burst(1'b1, 1'b0, 17'h1FFFF, 1, 4'h0, 1'b0);
    burst(1'b1, 1'b0, 17'h1FFFF, 1, 4'hA, 1'b0);
    burst(1'b0, 1'b0, 17'h1FFFF, 1, '1, 1'b0);
    s_float();
    s_trace();
    close_out();
  end

  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end
endmodule
